// >>> cpc_pkg.sv
package cpc_pkg;

    // ************************************************************
    // register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_PDATA = 8'h08;
    localparam logic [7:0] A_RDATA = 8'h0C;
    localparam logic [7:0] A_REPORT = 8'h10;
    localparam logic [7:0] A_PCOUNT = 8'h14;

    // control word bit positions
    localparam int C_START = 0;
    localparam int C_PUNCH = 1;
    localparam int C_READ = 2;
    localparam int C_IMAGE = 3;
    localparam int C_SORT = 4;
    localparam int C_REJ = 5;
    localparam int C_RESUME = 6;

    // card geometry and reset values
    localparam logic [6:0] COLS = 7'h50;
    localparam logic [6:0] EJECT_MIN = 7'h1C;
    localparam logic [6:0] PCOUNT_RST = 7'h50;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS = 50;
    localparam int PUNCH_CYCLE_NS = 16_600_000;
    localparam int PUNCH_CYCLE_CYC = PUNCH_CYCLE_NS / CLK_NS;
    localparam int REQ_LIMIT_NS = 400_000;
    localparam int REQ_LIMIT_CYC = REQ_LIMIT_NS / CLK_NS;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic rej;
        logic sort;
        logic image;
        logic read;
        logic punch;
    } cpc_cmd_s;

    typedef struct packed {
        logic [11:0] odd;
        logic [11:0] even;
    } cpc_cols_s;

    typedef struct packed {
        logic stop;
        logic intv;
        logic crej;
        logic rej;
        logic rd_ovr;
        logic ovr;
        logic chk;
        logic done;
    } cpc_report_s;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_REGS = 4'h1,
        S_REQ = 4'h2,
        S_FIRE = 4'h3,
        S_PACE = 4'h4,
        S_EJECT = 4'h5,
        S_FEED = 4'h6,
        S_DONE = 4'h7
    } cpc_state_e;

endpackage

// >>> cpc_card_punch_control.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module cpc_card_punch_control #(
    parameter int P_PUNCH_CYC = cpc_pkg::PUNCH_CYCLE_CYC,
    parameter int P_REQ_CYC = cpc_pkg::REQ_LIMIT_CYC,
    parameter logic [6:0] P_COLS = cpc_pkg::COLS
) (
    input wire logic i_mclk, // 20 MHz clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb write
    input wire logic [7:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error on unmapped
    output cpc_pkg::cpc_cols_s o_punch, // punch magnet pattern
    output logic o_punch_fire, // punch stroke pulse
    input wire logic [11:0] i_chk_odd, // odd column echo
    input wire logic [11:0] i_chk_even, // even column echo
    output logic o_register_card, // register at cols 1-2
    output logic o_advance, // two-column step pulse
    output logic o_eject, // eject card pulse
    output logic o_reject_gate, // reject stacker select
    output logic o_feed, // hopper pick pulse
    output logic o_read_feed, // feed through read station
    input wire logic i_rd_strobe, // read column strobe
    input wire logic [11:0] i_rd_col, // read column rows
    input wire logic i_primary_full, // primary stacker full
    input wire logic i_reject_full, // reject stacker full
    input wire logic i_misposition, // follower block wrong
    input wire logic i_manual_feed // operator feed switch
);

    // ************************************************************
    // bus decode
    // ************************************************************
    cpc_pkg::cpc_state_e state;
    cpc_pkg::cpc_cmd_s cmd;
    cpc_pkg::cpc_cmd_s cmd_in;
    cpc_pkg::cpc_report_s report;
    logic acc, wr, rd, go, resume, wr_pdata, pop, rd_report;
    logic [6:0] pcount;
    logic [6:0] eject_lim;
    logic [6:0] cols_next;
    logic [5:0] pos;
    logic [2:0] bcnt;
    logic [2:0] need;
    logic [19:0] pace_cnt;
    logic [12:0] req_cnt;
    logic pace_done, tmo, need_data, pdreq, sens_bad;
    logic chk_err, ovr, intv, crej, stopped, card_ready, report_valid;
    logic rd_active, rd_ovr, rd_fin, rd_start, rd_take;
    logic [6:0] rcol;
    logic [11:0] rd_hold;
    logic [1:0] rd_left;
    logic [7:0] rd_byte;

    function automatic logic hit(input logic [7:0] a);
        hit = (a == cpc_pkg::A_CTRL) || (a == cpc_pkg::A_STATUS) ||
              (a == cpc_pkg::A_PDATA) || (a == cpc_pkg::A_RDATA) ||
              (a == cpc_pkg::A_REPORT) || (a == cpc_pkg::A_PCOUNT);
    endfunction

    // translate mode: byte lands in the low rows, top rows unpunched
    function automatic logic [11:0] xlate(input logic [7:0] b);
        xlate = {4'h0, b};
    endfunction

    // access phase strobes; zero wait states
    assign acc = i_psel & i_penable;
    assign wr = acc & i_pwrite;
    assign rd = acc & ~i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = acc & ~hit(i_paddr);
    assign go = wr && i_paddr == cpc_pkg::A_CTRL && i_pwdata[cpc_pkg::C_START];
    assign resume = wr && i_paddr == cpc_pkg::A_CTRL && i_pwdata[cpc_pkg::C_RESUME];
    assign wr_pdata = wr && i_paddr == cpc_pkg::A_PDATA && pdreq;
    assign pop = rd && i_paddr == cpc_pkg::A_RDATA && rd_left != 2'h0;
    assign rd_report = rd && i_paddr == cpc_pkg::A_REPORT;

    // command fields as written with the start bit
    assign cmd_in = '{rej: i_pwdata[cpc_pkg::C_REJ], sort: i_pwdata[cpc_pkg::C_SORT],
                      image: i_pwdata[cpc_pkg::C_IMAGE], read: i_pwdata[cpc_pkg::C_READ],
                      punch: i_pwdata[cpc_pkg::C_PUNCH]};

    // any sensor that would spill cards stops punching before it starts
    assign sens_bad = i_primary_full | i_reject_full | i_misposition;

    // ************************************************************
    // punch sequencing terms
    // ************************************************************
    // short cards still travel 28 columns so the pinch roll can take them
    assign eject_lim = (pcount < cpc_pkg::EJECT_MIN) ? cpc_pkg::EJECT_MIN : pcount;
    assign cols_next = {pos, 1'b0} + 7'h02;
    assign need = cmd.image ? 3'h4 : 3'h2;
    assign need_data = ({pos, 1'b0} < pcount) && !ovr;
    // request only after the previous pair has been struck and cleared
    assign pdreq = (state == cpc_pkg::S_REQ) && need_data && (bcnt < need);
    assign pace_done = pace_cnt == 20'(P_PUNCH_CYC - 1);
    assign tmo = req_cnt == 13'(P_REQ_CYC - 1);

    // ************************************************************
    // apb registers
    // ************************************************************
    // read data is registered in the setup cycle, so it is stable in access
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
                cpc_pkg::A_CTRL: o_prdata <= {27'h0000000, cmd};
                cpc_pkg::A_STATUS: o_prdata <= {10'h000, pos, 7'h00, i_misposition,
                    i_reject_full, i_primary_full, card_ready, report_valid,
                    rd_left != 2'h0, pdreq, stopped, state != cpc_pkg::S_IDLE};
                cpc_pkg::A_RDATA: o_prdata <= {24'h000000, rd_byte};
                cpc_pkg::A_REPORT: o_prdata <= {24'h000000, report};
                cpc_pkg::A_PCOUNT: o_prdata <= {25'h0000000, pcount};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // punch column count, forced even and clamped to the card
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pcount <= cpc_pkg::PCOUNT_RST;
        end else if (wr && i_paddr == cpc_pkg::A_PCOUNT) begin
            if ({i_pwdata[6:1], 1'b0} > P_COLS) begin
                pcount <= P_COLS;
            end else begin
                pcount <= {i_pwdata[6:1], 1'b0};
            end
        end
    end

    // ************************************************************
    // punch buffers
    // ************************************************************
    // odd and even buffers hold still from fire to end of the cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_punch <= '0;
            bcnt <= 3'h0;
        end else if (state == cpc_pkg::S_PACE && pace_done) begin
            o_punch <= '0;
            bcnt <= 3'h0;
        end else if (wr_pdata) begin
            bcnt <= bcnt + 3'h1;
            if (cmd.image) begin
                // bits map one to one onto rows, top two bits dropped
                unique case (bcnt[1:0])
                    2'h0: o_punch.odd[11:6] <= i_pwdata[5:0];
                    2'h1: o_punch.odd[5:0] <= i_pwdata[5:0];
                    2'h2: o_punch.even[11:6] <= i_pwdata[5:0];
                    2'h3: o_punch.even[5:0] <= i_pwdata[5:0];
                endcase
            end else if (bcnt == 3'h0) begin
                o_punch.odd <= xlate(i_pwdata[7:0]);
            end else begin
                o_punch.even <= xlate(i_pwdata[7:0]);
            end
        end
    end

    // ************************************************************
    // timers
    // ************************************************************
    // pace timer spans the stroke and the step that follows it
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || state != cpc_pkg::S_PACE) begin
            pace_cnt <= 20'h00000;
        end else if (!pace_done) begin
            pace_cnt <= pace_cnt + 20'h00001;
        end
    end

    // data wait limit; a late channel ends punch data for this card
    // each accepted byte restarts the wait, so the limit applies per request
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || state != cpc_pkg::S_REQ || !pdreq || wr_pdata) begin
            req_cnt <= 13'h0000;
        end else if (!tmo) begin
            req_cnt <= req_cnt + 13'h0001;
        end
    end

    // ************************************************************
    // main sequencer
    // ************************************************************
    assign rd_start = state == cpc_pkg::S_IDLE && go && !stopped && cmd_in.read &&
                      !(cmd_in.punch && (sens_bad || !card_ready));

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= cpc_pkg::S_IDLE;
            cmd <= '0;
            pos <= 6'h00;
            chk_err <= 1'b0;
            ovr <= 1'b0;
            intv <= 1'b0;
            crej <= 1'b0;
            stopped <= 1'b0;
            card_ready <= 1'b0;
            report <= '0;
            report_valid <= 1'b0;
            o_register_card <= 1'b0;
            o_advance <= 1'b0;
            o_punch_fire <= 1'b0;
            o_eject <= 1'b0;
            o_reject_gate <= 1'b0;
            o_feed <= 1'b0;
        end else begin
            o_register_card <= 1'b0;
            o_advance <= 1'b0;
            o_punch_fire <= 1'b0;
            o_eject <= 1'b0;
            o_feed <= 1'b0;
            if (rd_report) begin
                report_valid <= 1'b0;
            end
            if (resume) begin
                stopped <= 1'b0;
            end
            unique case (state)
                cpc_pkg::S_IDLE: begin
                    // priming: one card per press, only into an empty station
                    if (stopped && i_manual_feed && !card_ready) begin
                        o_feed <= 1'b1;
                        card_ready <= 1'b1;
                    end else if (go && !stopped) begin
                        cmd <= cmd_in;
                        chk_err <= 1'b0;
                        ovr <= 1'b0;
                        intv <= 1'b0;
                        crej <= 1'b0;
                        if (!cmd_in.punch && !cmd_in.read) begin
                            crej <= 1'b1;
                            state <= cpc_pkg::S_DONE;
                        end else if (cmd_in.punch && (sens_bad || !card_ready)) begin
                            intv <= 1'b1;
                            state <= cpc_pkg::S_DONE;
                        end else if (cmd_in.punch) begin
                            state <= cpc_pkg::S_REGS;
                        end else begin
                            state <= cpc_pkg::S_DONE;
                        end
                    end
                end
                cpc_pkg::S_REGS: begin
                    o_register_card <= 1'b1;
                    o_reject_gate <= 1'b0;
                    card_ready <= 1'b0;
                    pos <= 6'h00;
                    state <= cpc_pkg::S_REQ;
                end
                cpc_pkg::S_REQ: begin
                    if (!need_data || bcnt == need) begin
                        state <= cpc_pkg::S_FIRE;
                    end else if (tmo) begin
                        ovr <= 1'b1;
                        state <= cpc_pkg::S_FIRE;
                    end
                end
                cpc_pkg::S_FIRE: begin
                    o_punch_fire <= 1'b1;
                    state <= cpc_pkg::S_PACE;
                end
                cpc_pkg::S_PACE: begin
                    if (pace_done) begin
                        // echo must match the pattern for both columns
                        if ({i_chk_odd, i_chk_even} != o_punch) begin
                            chk_err <= 1'b1;
                        end
                        pos <= pos + 6'h01;
                        if (cols_next >= eject_lim) begin
                            state <= cpc_pkg::S_EJECT;
                        end else begin
                            o_advance <= 1'b1;
                            state <= cpc_pkg::S_REQ;
                        end
                    end
                end
                cpc_pkg::S_EJECT: begin
                    o_eject <= 1'b1;
                    o_reject_gate <= cmd.rej || (cmd.sort && (chk_err || ovr));
                    // the read path brings the next card when reading
                    state <= cmd.read ? cpc_pkg::S_DONE : cpc_pkg::S_FEED;
                end
                cpc_pkg::S_FEED: begin
                    o_feed <= 1'b1;
                    card_ready <= 1'b1;
                    state <= cpc_pkg::S_DONE;
                end
                cpc_pkg::S_DONE: begin
                    // status waits for the read card to clear the station
                    if (!rd_active) begin
                        report <= '{stop: (chk_err || ovr || rd_ovr) && !cmd.sort || intv,
                                    intv: intv, crej: crej,
                                    rej: cmd.rej || (cmd.sort && (chk_err || ovr)),
                                    rd_ovr: rd_ovr, ovr: ovr, chk: chk_err,
                                    done: 1'b1};
                        report_valid <= 1'b1;
                        if (((chk_err || ovr || rd_ovr) && !cmd.sort) || intv) begin
                            stopped <= 1'b1;
                        end
                        state <= cpc_pkg::S_IDLE;
                    end
                end
                default: state <= cpc_pkg::S_IDLE;
            endcase
            // a read card reaching the wait station wins over the clear
            if (rd_fin) begin
                card_ready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // read station path
    // ************************************************************
    assign rd_fin = i_rd_strobe && rd_active && rcol == P_COLS - 7'h01;
    // a column is taken only when the last one has gone out
    assign rd_take = rd_left == 2'h0 || (rd_left == 2'h1 && pop);
    always_comb begin
        rd_byte = 8'h00;
        if (!cmd.image) begin
            rd_byte = rd_hold[7:0];
        end else if (rd_left == 2'h2) begin
            rd_byte = {2'h0, rd_hold[11:6]};
        end else if (rd_left == 2'h1) begin
            rd_byte = {2'h0, rd_hold[5:0]};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rd_active <= 1'b0;
            rd_ovr <= 1'b0;
            rcol <= 7'h00;
            rd_hold <= 12'h000;
            rd_left <= 2'h0;
            o_read_feed <= 1'b0;
        end else begin
            o_read_feed <= rd_start;
            if (rd_start) begin
                rd_active <= 1'b1;
                rd_ovr <= 1'b0;
                rcol <= 7'h00;
            end else if (i_rd_strobe && rd_active) begin
                rcol <= rcol + 7'h01;
                if (rd_fin) begin
                    rd_active <= 1'b0;
                end
                if (!rd_ovr && rd_take) begin
                    rd_hold <= i_rd_col;
                    rd_left <= cmd.image ? 2'h2 : 2'h1;
                end else begin
                    rd_ovr <= 1'b1;
                    if (pop) begin
                        rd_left <= rd_left - 2'h1;
                    end
                end
            end else if (pop) begin
                rd_left <= rd_left - 2'h1;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [19:0] gap;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || o_punch_fire) begin
            gap <= 20'h00000;
        end else if (gap != 20'hFFFFF) begin
            gap <= gap + 20'h00001;
        end
    end

    a_pace_gap: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_punch_fire && pos != 6'h00 |-> gap >= 20'(P_PUNCH_CYC - 1))
        else $error("punch strokes closer than the punch cycle");
    a_req_commit: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_punch_fire |-> !pdreq [*2])
        else $error("data request raised before pair was struck");
    a_image_upper: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_pdata && cmd.image && bcnt == 3'h0 |=> o_punch.odd[11:6] == $past(i_pwdata[5:0]))
        else $error("image byte 0 not on upper half");
    a_image_lower: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_pdata && cmd.image && bcnt == 3'h1 |=> o_punch.odd[5:0] == $past(i_pwdata[5:0]))
        else $error("image byte 1 not on lower half");
    a_reject_pick: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_eject |-> o_reject_gate == (cmd.rej || (cmd.sort && (chk_err || ovr))))
        else $error("wrong stacker chosen at eject");
    a_stop_error: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state == cpc_pkg::S_DONE && !rd_active && chk_err && !cmd.sort |=> stopped)
        else $error("error without sort did not stop");
    a_sensor_block: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state == cpc_pkg::S_IDLE && go && !stopped && cmd_in.punch && sens_bad
        |=> state == cpc_pkg::S_DONE ##1 report.intv)
        else $error("punch started with a blocking sensor");
    a_read_pad: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        rd_left != 2'h0 && cmd.image |-> rd_byte[7:6] == 2'h0)
        else $error("image read byte not zero padded");
    a_feed_once: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_feed |=> !o_feed ##1 card_ready)
        else $error("manual feed picked more than one card");
    a_status_end: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state == cpc_pkg::S_DONE && !rd_active |=> report_valid && report.done)
        else $error("no status at command end");
    a_register_first: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        o_register_card |-> pos == 6'h00 && state == cpc_pkg::S_REQ)
        else $error("card not registered at first columns");

endmodule

// >>> cpc_punch_model.sv
`timescale 1ns/1ps
module cpc_punch_model (
    input wire cpc_pkg::cpc_cols_s i_punch, // magnet pattern
    input wire logic i_bad, // corrupt the echo
    output logic [11:0] o_chk_odd, // odd column echo
    output logic [11:0] o_chk_even // even column echo
);
    // holes follow magnets one to one; a fault inverts the bottom odd row
    assign o_chk_odd = i_punch.odd ^ {11'h000, i_bad};
    assign o_chk_even = i_punch.even;
endmodule

// >>> cpc_card_punch_control_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpc_card_punch_control_bench;
    logic i_mclk = 1'b0;
    logic rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, mfeed = 1'b0, bad = 1'b0;
    logic rstb = 1'b0;
    logic [2:0] sens = 3'h0;
    logic [11:0] col = 12'h000;
    logic [7:0] card[56];
    logic rcard, adv, ej, rfeed;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat, prdata;
    logic pready, pslverr, err, fire, rgate, feed;
    logic [11:0] chko, chke;
    cpc_pkg::cpc_cols_s punch, ex;
    cpc_pkg::cpc_cols_s expq[$];
    int miscompares = 0, compares = 0, nfeed = 0, nreg = 0, nadv = 0, nej = 0, nrf = 0;
    always #25 i_mclk = ~i_mclk;
    cpc_card_punch_control #(.P_PUNCH_CYC(20), .P_REQ_CYC(40), .P_COLS(cpc_pkg::COLS)) DUT (
        .i_mclk(i_mclk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_punch(punch), .o_punch_fire(fire), .i_chk_odd(chko),
        .i_chk_even(chke), .o_register_card(rcard), .o_advance(adv), .o_eject(ej),
        .o_reject_gate(rgate), .o_feed(feed), .o_read_feed(rfeed), .i_rd_strobe(rstb),
        .i_rd_col(col), .i_primary_full(sens[0]), .i_reject_full(sens[1]),
        .i_misposition(sens[2]), .i_manual_feed(mfeed));
    cpc_punch_model PM (.i_punch(punch), .i_bad(bad), .o_chk_odd(chko), .o_chk_even(chke));
    // ************************************************************
    // bus tasks and result watcher
    // ************************************************************
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge i_mclk);
        pen <= 1'b1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
    endtask
    // polling instead of fixed waits: the data request timing is the design's
    task wait_bit(input int n);
        do apb(1'b0, cpc_pkg::A_STATUS, 32'h0); while (rdat[n] !== 1'b1);
    endtask
    task punch_card(input logic b, input logic rep);
        logic [5:0] h[4];
        logic [7:0] v;
        bad <= b;
        apb(1'b1, cpc_pkg::A_CTRL, 32'h1B);
        for (int p = 0; p < 14; p++) begin
            for (int k = 0; k < 4; k++) begin
                // a repunch resends exactly the bytes of the rejected card
                v = rep ? card[p * 4 + k] : 8'($urandom);
                card[p * 4 + k] = v;
                h[k] = v[5:0];
                wait_bit(2);
                apb(1'b1, cpc_pkg::A_PDATA, {24'h000000, v});
            end
            expq.push_back({h[0], h[1], h[2], h[3]});
        end
        wait_bit(4);
        apb(1'b0, cpc_pkg::A_REPORT, 32'h0);
    endtask
    task complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // each stroke is compared with the oldest pair handed over
    always @(posedge i_mclk) begin
        if (feed === 1'b1) nfeed++;
        if (rcard === 1'b1) nreg++;
        if (adv === 1'b1) nadv++;
        if (ej === 1'b1) nej++;
        if (rfeed === 1'b1) nrf++;
        if (fire === 1'b1) begin
            if (expq.size() == 0) `CHK(1'b0, 1'b1)
            else begin
                ex = expq.pop_front();
                `CHK(punch, ex)
            end
        end
    end
    initial begin
        #2_000_000;
        miscompares++;
        complete_run;
    end
    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        void'($urandom(33));
        repeat (20) @(posedge i_mclk);
        rst <= 1'b0;
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b0, cpc_pkg::A_PCOUNT, 32'h0);
        `CHK(rdat[6:0], cpc_pkg::PCOUNT_RST)
        apb(1'b1, cpc_pkg::A_PCOUNT, 32'h51);
        apb(1'b0, cpc_pkg::A_PCOUNT, 32'h0);
        `CHK(rdat[6:0], 7'h50)
        apb(1'b1, cpc_pkg::A_PCOUNT, 32'h1C);
        // no card waiting: the punch command must stop the unit
        apb(1'b1, cpc_pkg::A_CTRL, 32'h03);
        wait_bit(4);
        apb(1'b0, cpc_pkg::A_REPORT, 32'h0);
        `CHK(rdat[7:6], 2'b11)
        // switch held three cycles still picks a single card
        mfeed <= 1'b1;
        repeat (3) @(posedge i_mclk);
        mfeed <= 1'b0;
        repeat (10) @(posedge i_mclk);
        `CHK(nfeed, 1)
        apb(1'b1, cpc_pkg::A_CTRL, 32'h40);
        // a card waits, but any random blocking sensor refuses the punch
        sens <= 3'($urandom_range(7, 1));
        apb(1'b1, cpc_pkg::A_CTRL, 32'h03);
        wait_bit(4);
        `CHK(rdat[8:6], sens)
        apb(1'b0, cpc_pkg::A_REPORT, 32'h0);
        `CHK(rdat[7:6], 2'b11)
        sens <= 3'h0;
        apb(1'b1, cpc_pkg::A_CTRL, 32'h40);
        // translate read of a whole card, one strobe per column, popped at once
        apb(1'b1, cpc_pkg::A_CTRL, 32'h05);
        for (int c = 0; c < 80; c++) begin
            col <= 12'($urandom);
            rstb <= 1'b1;
            @(posedge i_mclk);
            rstb <= 1'b0;
            apb(1'b0, cpc_pkg::A_RDATA, 32'h0);
            `CHK(rdat[7:0], col[7:0])
        end
        wait_bit(4);
        `CHK(rdat[5], 1'b1)
        apb(1'b0, cpc_pkg::A_REPORT, 32'h0);
        `CHK(rdat[7:0], 8'h01)
        `CHK(nrf, 1)
        punch_card(1'b0, 1'b0);
        `CHK(rdat[7:0], 8'h01)
        `CHK(rgate, 1'b0)
        `CHK(nfeed, 2)
        `CHK(nreg, 1)
        `CHK(nadv, 13)
        `CHK(nej, 1)
        punch_card(1'b1, 1'b0);
        `CHK({rdat[7], rdat[4]}, 2'b01)
        `CHK(rgate, 1'b1)
        // the rejected card is punched again from the same bytes
        punch_card(1'b0, 1'b1);
        `CHK(rdat[7:0], 8'h01)
        `CHK(rgate, 1'b0)
        `CHK(nej, 3)
        `CHK(expq.size(), 0)
        complete_run;
    end
endmodule
